// file: ssrwg_defines.svh
// Purpose: Shared constants of the supply supervisor and write guard
// Assumes: Clock of 20 MHz
// Notes: Times keep their printed unit; cycle counts derive from them
`ifndef SSRWG_DEFINES_SVH
`define SSRWG_DEFINES_SVH

// Clock rate in hertz
`define SSRWG_CLK_HZ 20000000
// Reset timeout, typical, in milliseconds
`define SSRWG_TIMEOUT_MS 200
`define SSRWG_TIMEOUT_CYC (`SSRWG_TIMEOUT_MS * (`SSRWG_CLK_HZ / 1000))
// Manual reset debounce window in microseconds
`define SSRWG_DEBOUNCE_US 1000
`define SSRWG_DEBOUNCE_CYC (`SSRWG_DEBOUNCE_US * (`SSRWG_CLK_HZ / 1000000))
// Longest write cycle in milliseconds, rounded down to cycles
`define SSRWG_WRITE_MS 5
`define SSRWG_WRITE_CYC (`SSRWG_WRITE_MS * (`SSRWG_CLK_HZ / 1000))
// Counter width shared by all timers
`define SSRWG_CNT_W 32

`endif

// file: ssrwg_pkg.sv
// Purpose: Types of the supply supervisor and write guard
// Assumes: ssrwg_defines.svh is on the include path
// Notes: Holds types only; numbers live in the defines header
`include "ssrwg_defines.svh"

package ssrwg_pkg;

	// Timer word
	typedef logic [`SSRWG_CNT_W-1:0] ssrwg_cnt_t;

	// Reset sequencer phases
	typedef enum logic [1:0] {
		SSRWG_HOLD,    // A cause is present
		SSRWG_TIMEOUT, // Counting the release delay
		SSRWG_RUN      // Reset released
	} ssrwg_phase_t;

	// Debouncer state
	typedef struct packed {
		logic sampled;   // Last raw level seen
		ssrwg_cnt_t cnt; // Cycles the raw level has held
		logic stable;    // Accepted level
	} ssrwg_deb_t;

	// Open-drain pin drive
	typedef struct packed {
		logic level; // Level driven while enabled
		logic oe;    // High while driving
	} ssrwg_od_t;

	// Whole state of the top module
	typedef struct packed {
		ssrwg_phase_t phase; // Sequencer phase
		ssrwg_cnt_t tcnt;    // Reset timeout count
		ssrwg_od_t rst_n;    // Active-low reset pin
		ssrwg_od_t rst_hi;   // Active-high reset pin
		logic powered;       // Supply has reached threshold once
		logic inhibit;       // Memory writes blocked
		logic busy;          // Write cycle in progress
		ssrwg_cnt_t wcnt;    // Write cycle count
	} ssrwg_state_t;

endpackage : ssrwg_pkg

// file: ssrwg_debounce.sv
// Purpose: Debounce the manual reset level
// Assumes: Input is synchronous to the clock
// Notes: Output changes only after the input held steady a full window
`timescale 1ns/1ps
`include "ssrwg_defines.svh"

module ssrwg_debounce #(
	parameter int DEB_CYC = `SSRWG_DEBOUNCE_CYC
) (
	input wire logic ref_clk_i, // Clock
	input wire logic reset_i,   // Synchronous reset, active high
	input wire logic raw_i,     // Raw level
	output logic stable_o       // Debounced level
);

	ssrwg_pkg::ssrwg_deb_t st;
	ssrwg_pkg::ssrwg_deb_t next_st;

	// Window must be at least one cycle
	if (DEB_CYC < 1) begin : g_bad
		$error("DEB_CYC must be at least 1");
	end

	////////////////////////////////////////////////////////////////////
	// Next state: restart the window on any change of the raw level
	always_comb begin
		next_st = st;
		next_st.sampled = raw_i;
		if (raw_i != st.sampled) begin // Bounce restarts window
			next_st.cnt = '0;
		end else if (raw_i != st.stable) begin
			if (st.cnt == ssrwg_pkg::ssrwg_cnt_t'(DEB_CYC - 1)) begin
				next_st.stable = raw_i;
				next_st.cnt = '0;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end else begin
			next_st.cnt = '0; // Settled
		end
	end

	// Register; idle level is high, as the pull-up gives
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st <= '{sampled: 1'b1, cnt: '0, stable: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign stable_o = st.stable;

	////////////////////////////////////////////////////////////////////
	// Accepted level only moves at the end of a full steady window
	property p_deb_window;
		@(posedge ref_clk_i) disable iff (reset_i)
		(st.stable != $past(st.stable)) |->
			($past(st.cnt) == ssrwg_pkg::ssrwg_cnt_t'(DEB_CYC - 1));
	endproperty
	a_deb_window: assert property (p_deb_window)
		else $error("Debounced level moved before window end");

endmodule : ssrwg_debounce

// file: ssrwg_top.sv
// Purpose: Supply supervisor with reset timeout and write guard
// Assumes: Comparator and pin inputs synchronous to ref_clk_i
// Notes: Pin pulls are modelled by the *_en_i driven indications
//
// How it works
// - Supply low asserts both reset outputs
// - Hold reset 200 ms after supply recovers
// - External low on reset pin starts reset
// - Manual reset low asserts both outputs
// - Hold while manual low, then full timeout
// - Manual reset input is debounced first
// - Undriven manual reset input reads high
// - Write-protect high blocks all array writes
// - Write-protect low or floating allows writes
// - Supply low or never reached inhibits writes
// - Reduced option: low reset only, no protect
// - Write cycle disables bus up to 5 ms
`timescale 1ns/1ps
`include "ssrwg_defines.svh"

module ssrwg_top #(
	parameter bit FULL_OPTION = 1'b1,                // Both outputs and WP
	parameter int TIMEOUT_CYC = `SSRWG_TIMEOUT_CYC,  // Release delay
	parameter int DEBOUNCE_CYC = `SSRWG_DEBOUNCE_CYC, // Debounce window
	parameter int WRITE_CYC = `SSRWG_WRITE_CYC       // Write cycle length
) (
	input wire logic ref_clk_i,           // Clock, 20 MHz
	input wire logic reset_i,             // Power-on reset, active high
	input wire logic vcc_low_i,           // Supply below threshold
	input wire logic manual_reset_in_i,   // Manual reset level
	input wire logic manual_reset_in_en_i,// Manual reset pin is driven
	input wire logic rst_n_i,             // Sensed low reset pin level
	input wire logic wp_i,                // Write-protect level
	input wire logic wp_en_i,             // Write-protect pin is driven
	input wire logic write_stop_i,        // Stop ending a write sequence
	output logic rst_n_o,                 // Low reset pin drive level
	output logic rst_n_oe_o,              // Low reset pin drive enable
	output logic rst_hi_o,                // High reset pin drive level
	output logic rst_hi_oe_o,             // High reset pin drive enable
	output logic write_inhibit_o,         // Memory writes blocked
	output logic write_busy_o,            // Internal write in progress
	output logic bus_disable_o            // Serial interface ignored
);

	ssrwg_pkg::ssrwg_state_t st;      // Registered state
	ssrwg_pkg::ssrwg_state_t next_st; // Next state
	logic mr_eff;  // Manual reset with pull-up applied
	logic mr_deb;  // Debounced manual reset
	logic wp_eff;  // Write protect with pull-down, option applied
	logic ext_req; // Outside party pulls the low reset pin
	logic cause;   // Any reset cause now

	// Counts the logic cannot serve
	if (TIMEOUT_CYC < 1 || WRITE_CYC < 1 || DEBOUNCE_CYC < 1) begin : g_bad
		$error("Timer counts must be at least 1");
	end

	////////////////////////////////////////////////////////////////////
	// Pin conditioning

	// Floating input reads high and causes no reset
	assign mr_eff = manual_reset_in_en_i ? manual_reset_in_i : 1'b1;

	// Floating input reads low; reduced option has no such pin
	assign wp_eff = FULL_OPTION && wp_en_i && wp_i;

	// Only sensed while we are not pulling it ourselves, else we latch
	assign ext_req = !st.rst_n.oe && !rst_n_i;

	ssrwg_debounce #(
		.DEB_CYC(DEBOUNCE_CYC)
	) u_deb (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.raw_i(mr_eff),
		.stable_o(mr_deb)
	);

	// Gather reset causes
	assign cause = vcc_low_i || !mr_deb || ext_req;

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_st = st;
		// Reset sequencer
		unique case (st.phase)
			ssrwg_pkg::SSRWG_HOLD: begin
				if (!cause) begin // Cause gone, start counting
					next_st.phase = ssrwg_pkg::SSRWG_TIMEOUT;
					next_st.tcnt = '0;
				end
			end
			ssrwg_pkg::SSRWG_TIMEOUT: begin
				if (cause) begin // Any cause restarts the count
					next_st.phase = ssrwg_pkg::SSRWG_HOLD;
					next_st.tcnt = '0;
				end else if (st.tcnt ==
					ssrwg_pkg::ssrwg_cnt_t'(TIMEOUT_CYC - 1)) begin
					next_st.phase = ssrwg_pkg::SSRWG_RUN;
				end else begin
					next_st.tcnt = st.tcnt + 1'b1;
				end
			end
			ssrwg_pkg::SSRWG_RUN: begin
				if (cause) begin
					next_st.phase = ssrwg_pkg::SSRWG_HOLD;
					next_st.tcnt = '0;
				end
			end
		endcase
		// Both pins follow one phase, so they release together
		next_st.rst_n.level = 1'b0;
		next_st.rst_n.oe = (next_st.phase != ssrwg_pkg::SSRWG_RUN);
		next_st.rst_hi.level = 1'b1;
		next_st.rst_hi.oe = FULL_OPTION && next_st.rst_n.oe;
		// Power-up latch: set once supply first reaches threshold
		if (!vcc_low_i) begin
			next_st.powered = 1'b1;
		end
		// Write guard
		next_st.inhibit = vcc_low_i || !next_st.powered || wp_eff;
		// Write cycle timer; stop of a write starts it if writes allowed
		if (st.busy) begin
			if (st.wcnt == ssrwg_pkg::ssrwg_cnt_t'(WRITE_CYC - 1)) begin
				next_st.busy = 1'b0;
				next_st.wcnt = '0;
			end else begin
				next_st.wcnt = st.wcnt + 1'b1;
			end
		end else if (write_stop_i && !st.inhibit) begin
			next_st.busy = 1'b1;
			next_st.wcnt = '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register; reset holds every reset output asserted
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st <= '{phase: ssrwg_pkg::SSRWG_HOLD, tcnt: '0,
				rst_n: '{level: 1'b0, oe: 1'b1},
				rst_hi: '{level: 1'b1, oe: FULL_OPTION},
				powered: 1'b0, inhibit: 1'b1, busy: 1'b0, wcnt: '0};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign rst_n_o = st.rst_n.level;
	assign rst_n_oe_o = st.rst_n.oe;
	assign rst_hi_o = st.rst_hi.level;
	assign rst_hi_oe_o = st.rst_hi.oe;
	assign write_inhibit_o = st.inhibit;
	assign write_busy_o = st.busy;
	assign bus_disable_o = st.busy;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	property p_supply_low;
		vcc_low_i |=> rst_n_oe_o && (rst_hi_oe_o == FULL_OPTION);
	endproperty
	a_supply_low: assert property (p_supply_low)
		else $error("Supply low did not assert reset");

	property p_release_delay;
		$fell(rst_n_oe_o) |->
			$past(st.tcnt) == ssrwg_pkg::ssrwg_cnt_t'(TIMEOUT_CYC - 1) &&
			$past(st.phase) == ssrwg_pkg::SSRWG_TIMEOUT;
	endproperty
	a_release_delay: assert property (p_release_delay)
		else $error("Reset released before timeout end");

	property p_ext_pull;
		(!rst_n_oe_o && !rst_n_i) |=> rst_n_oe_o [*2];
	endproperty
	a_ext_pull: assert property (p_ext_pull)
		else $error("External pull did not start reset");

	property p_manual;
		!mr_deb |=> rst_n_oe_o;
	endproperty
	a_manual: assert property (p_manual)
		else $error("Manual reset did not assert reset");

	property p_manual_hold;
		$rose(mr_deb) |-> rst_n_oe_o ##1 st.tcnt == '0;
	endproperty
	a_manual_hold: assert property (p_manual_hold)
		else $error("Timeout did not start at manual release");

	property p_pullup;
		!manual_reset_in_en_i |-> mr_eff;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("Floating manual reset not read high");

	property p_wp_block;
		(FULL_OPTION && wp_en_i && wp_i) |=> write_inhibit_o;
	endproperty
	a_wp_block: assert property (p_wp_block)
		else $error("Write protect did not inhibit writes");

	property p_wp_allow;
		(!wp_eff && !vcc_low_i && st.powered) |=> !write_inhibit_o;
	endproperty
	a_wp_allow: assert property (p_wp_allow)
		else $error("Writes blocked with protect low");

	// Supply low blocks next cycle; never-powered state blocks now, since
	// the first good supply sample may lift the block in the same edge
	property p_supply_inhibit;
		(vcc_low_i |=> write_inhibit_o) and
			(!st.powered |-> write_inhibit_o);
	endproperty
	a_supply_inhibit: assert property (p_supply_inhibit)
		else $error("Supply low did not inhibit writes");

	property p_reduced;
		!FULL_OPTION |-> !rst_hi_oe_o;
	endproperty
	a_reduced: assert property (p_reduced)
		else $error("High reset driven in reduced option");

	property p_write_cycle;
		$fell(write_busy_o) |->
			$past(st.wcnt) == ssrwg_pkg::ssrwg_cnt_t'(WRITE_CYC - 1) &&
			!bus_disable_o;
	endproperty
	a_write_cycle: assert property (p_write_cycle)
		else $error("Write cycle length wrong");

	// Both pins assert and release on the same edge
	property p_together;
		rst_hi_oe_o == (FULL_OPTION && rst_n_oe_o);
	endproperty
	a_together: assert property (p_together)
		else $error("Reset outputs released apart");

	c_release: cover property ($fell(rst_n_oe_o));
	c_manual: cover property ($fell(mr_deb) ##[1:50] $rose(mr_deb));
	c_write: cover property ($rose(write_busy_o));
	c_ext: cover property (!rst_n_oe_o && !rst_n_i);

endmodule : ssrwg_top

// file: ssrwg_partner.sv
// Purpose: Controller reset pin and push-button seen from the supervisor
// Assumes: One clock shared with the supervisor
// Notes: Pin pull-up resolves the low reset wire
`timescale 1ns/1ps

module ssrwg_partner (
	input wire logic ref_clk_i,  // Clock
	input wire logic rst_n_oe_i, // Supervisor pulls reset low
	input wire logic mcu_pull_i, // Controller forces reset low
	input wire logic press_i,    // Button held down
	input wire logic conn_i,     // Button wired to the pin
	output logic rst_n_w_o,      // Resolved low reset wire
	output logic manual_o,       // Button contact level
	output logic manual_en_o     // Button drives the pin
);
	logic [1:0] bounce = 2'h0; // Bounce cycles left
	logic held = 1'b0;         // Settled button state
	logic tog = 1'b0;          // Junk level while unwired

	// Wired-AND with pull-up; either party may pull low
	assign rst_n_w_o = ~(rst_n_oe_i | mcu_pull_i);
	assign manual_en_o = conn_i;

	////////////////////////////////////////////////////////////////////
	// Contacts chatter a few cycles, shorter than any sane debounce
	always @(posedge ref_clk_i) begin
		tog <= ~tog;
		if (press_i != held) begin
			held <= press_i;
			bounce <= 2'h3;
		end else if (bounce != 2'h0) begin
			bounce <= bounce - 2'h1;
		end
	end
	// Unwired pin shows a changing level, never the last one
	assign manual_o = !conn_i ? tog : (bounce != 2'h0) ? bounce[0] : ~held;
endmodule : ssrwg_partner

// file: ssrwg_top_tb.sv
// Purpose: Self-checking bench of the supply supervisor
// Assumes: Shortened timeout, debounce and write cycle counts
// Notes: Drivers queue expected output changes with cycle windows
`timescale 1ns/1ps

module ssrwg_top_tb;
	localparam int T = 20; // Reset timeout cycles
	localparam int D = 4;  // Debounce window cycles
	localparam int W = 10; // Write cycle cycles
	typedef struct {logic [4:0] v; int lo; int hi;} ssrwg_note_t;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic vcc_low_i = 1'b1;
	logic wp_i = 1'b0;
	logic wp_en_i = 1'b0;
	logic write_stop_i = 1'b0;
	logic mcu_pull = 1'b0; // Controller forces reset
	logic press = 1'b0;    // Button held
	logic conn = 1'b1;     // Button wired
	logic manual_w, manual_en_w, rst_n_w, rst_n_w2;
	logic rst_n_o, rst_n_oe_o, rst_hi_o, rst_hi_oe_o;
	logic write_inhibit_o, write_busy_o, bus_disable_o;
	logic r2_oe, r2_hi_oe, r2_inh; // Reduced build outputs
	int cyc = 0;
	int n_fail = 0;
	int n_checks = 0;
	int k;
	ssrwg_note_t notes[$]; // Expected changes, oldest first
	ssrwg_note_t n;
	logic [4:0] prev = 5'h1c;

	////////////////////////////////////////////////////////////////////
	ssrwg_partner ssrwg_partner_i (.ref_clk_i(ref_clk_i),
		.rst_n_oe_i(rst_n_oe_o), .mcu_pull_i(mcu_pull), .press_i(press),
		.conn_i(conn), .rst_n_w_o(rst_n_w), .manual_o(manual_w),
		.manual_en_o(manual_en_w));
	ssrwg_top #(.TIMEOUT_CYC(T), .DEBOUNCE_CYC(D), .WRITE_CYC(W)) ssrwg_top_i (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .vcc_low_i(vcc_low_i),
		.manual_reset_in_i(manual_w), .manual_reset_in_en_i(manual_en_w),
		.rst_n_i(rst_n_w), .wp_i(wp_i), .wp_en_i(wp_en_i),
		.write_stop_i(write_stop_i), .rst_n_o(rst_n_o),
		.rst_n_oe_o(rst_n_oe_o), .rst_hi_o(rst_hi_o),
		.rst_hi_oe_o(rst_hi_oe_o), .write_inhibit_o(write_inhibit_o),
		.write_busy_o(write_busy_o), .bus_disable_o(bus_disable_o));
	// Reduced build shares every input but its own reset wire
	assign rst_n_w2 = ~(r2_oe | mcu_pull);
	ssrwg_top #(.FULL_OPTION(1'b0), .TIMEOUT_CYC(T), .DEBOUNCE_CYC(D),
		.WRITE_CYC(W)) ssrwg_top_i2 (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .vcc_low_i(vcc_low_i),
		.manual_reset_in_i(manual_w), .manual_reset_in_en_i(manual_en_w),
		.rst_n_i(rst_n_w2), .wp_i(wp_i), .wp_en_i(wp_en_i),
		.write_stop_i(write_stop_i), .rst_n_o(), .rst_n_oe_o(r2_oe),
		.rst_hi_o(), .rst_hi_oe_o(r2_hi_oe), .write_inhibit_o(r2_inh),
		.write_busy_o(), .bus_disable_o());

	////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) cyc <= cyc + 1;

	task automatic chk(input string what, input logic [4:0] e,
		input logic [4:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	task automatic step(input int c);
		repeat (c) @(posedge ref_clk_i);
		#1;
	endtask : step

	task automatic note(input logic [4:0] v, input int lo, input int hi);
		notes.push_back('{v, lo, hi});
	endtask : note

	// Stop pulse of one cycle
	task automatic stop_pulse;
		write_stop_i = 1'b1;
		step(1);
		write_stop_i = 1'b0;
	endtask : stop_pulse

	function automatic logic [4:0] cur();
		return {rst_n_oe_o, rst_hi_oe_o, write_inhibit_o, write_busy_o,
			bus_disable_o};
	endfunction : cur

	////////////////////////////////////////////////////////////////////
	// Watcher: each output change takes the oldest note
	always @(negedge ref_clk_i) begin
		if (!reset_i) begin
			chk("drive levels", 5'h01, {3'h0, rst_n_o, rst_hi_o});
			chk("reduced high oe", 5'h00, {4'h0, r2_hi_oe});
			if (cur() !== prev) begin
				prev = cur();
				if (notes.size() == 0) begin
					chk("spare change", 5'h00, 5'h1f);
				end else begin
					n = notes.pop_front();
					chk("outputs", n.v, prev);
					chk("window", 5'h01, {4'h0, cyc >= n.lo && cyc <= n.hi});
				end
			end
		end
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		n_fail++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hbedb134b));
		step(8);
		reset_i = 1'b0;
		step(1);
		chk("after reset", 5'h1c, cur());
		chk("reduced after reset", 5'h03, {3'h0, r2_oe, r2_inh});
		step(2);
		stop_pulse();
		step(3);
		k = cyc;
		vcc_low_i = 1'b0;
		note(5'h18, k + 1, k + 3);
		note(5'h00, k + T, k + T + 3);
		step(T + 6 + $urandom_range(0, 7));
		// Write cycle, extra stop ignored
		k = cyc;
		stop_pulse();
		note(5'h03, k + 1, k + 1);
		note(5'h00, k + W, k + W + 2);
		step($urandom_range(1, 4));
		stop_pulse();
		step(W + 4);
		// Protect then floating
		k = cyc;
		wp_en_i = 1'b1;
		wp_i = 1'b1;
		note(5'h04, k + 1, k + 1);
		step(2);
		stop_pulse();
		chk("reduced inhibit", 5'h00, {4'h0, r2_inh});
		chk("reduced oe", 5'h00, {4'h0, r2_oe});
		k = cyc;
		wp_en_i = 1'b0;
		// Floating pin may show any level; the pull-down must win
		wp_i = 1'($urandom_range(0, 1));
		note(5'h00, k + 1, k + 1);
		step(3);
		// Unwired button reads high
		conn = 1'b0;
		press = 1'b1;
		step(D + 6);
		press = 1'b0;
		step(5);
		conn = 1'b1;
		step(2);
		// Bouncy press held past a timeout
		k = cyc;
		press = 1'b1;
		note(5'h18, k + D, k + D + 8);
		step(T + 10);
		k = cyc;
		press = 1'b0;
		note(5'h00, k + D + T, k + D + T + 6);
		step(T + D + 12);
		// Controller pull, then supply glitch restarts count
		k = cyc;
		mcu_pull = 1'b1;
		note(5'h18, k + 1, k + 2);
		step(2);
		mcu_pull = 1'b0;
		step(8);
		k = cyc;
		vcc_low_i = 1'b1;
		note(5'h1c, k + 1, k + 2);
		step(1);
		vcc_low_i = 1'b0;
		note(5'h18, k + 2, k + 4);
		note(5'h00, k + T, k + T + 5);
		for (int i = 0; i < 100 && notes.size() != 0; i++) step(1);
		chk("notes left", 5'h00, (notes.size() != 0) ? 5'h1f : 5'h00);
		end_sim();
	end
endmodule : ssrwg_top_tb
